// ### hw/rfd_dma.v
// Purpose : Two general byte/word DMA channels and a converter scan channel on the system bus
// Assumes : Grant stays high until bus_req falls; sys_rdata is valid the cycle after sys_rd
// Notes   : APB register slave, zero wait states, pslverr on unmapped words
//
// Register access over APB was chosen for this implementation.

`timescale 1ns/100ps

`include "rfd_regs.vh"

module rfd_dma
(
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    input  wire [3:0]  pstrb,
    output reg  [31:0] prdata,
    output wire        pready,
    output wire        pslverr,
    output wire        bus_req,
    input  wire        bus_gnt,
    output wire [11:0] sys_addr,
    output wire        sys_rd,
    output wire        sys_wr,
    output wire [7:0]  sys_wdata,
    input  wire [7:0]  sys_rdata,
    input  wire [7:0]  dma_trig,
    input  wire        adc_done,
    input  wire [15:0] adc_result,
    output wire        adc_start,
    output wire [3:0]  adc_input_sel,
    output wire        irq_ch0,
    output wire        irq_ch1,
    output wire        irq_adc
);
// ----------------------------------------------------------------
// Address helper
// ----------------------------------------------------------------
    // Source when want_dst is low, destination when high
    function [11:0] xfer_addr;
        input        want_dst;
        input        dir;
        input [11:0] cur;
        input [11:0] per;
        input        upper;
        begin
            if (want_dst ^ dir)
                xfer_addr = per + {11'h000, upper};
            else
                xfer_addr = cur + {11'h000, upper};
        end
    endfunction
// ----------------------------------------------------------------
// Declarations
// ----------------------------------------------------------------
    reg  [7:0]  ctl_q [0:1];
    reg  [31:0] cfg_q [0:1];
    reg  [11:0] cur_q [0:1];
    reg  [1:0]  irq_ch_q;
    wire [11:0] per_a [0:1];
    wire [11:0] start_a [0:1];
    wire [11:0] end_a [0:1];
    wire [1:0]  ch_req;
    reg  [6:0]  adc_base_q;
    reg  [7:0]  adc_ctl_q;
    reg  [3:0]  adc_in_q;
    reg         adc_pend_q;
    reg  [15:0] adc_res_q;
    reg         adc_start_q;
    reg         irq_adc_q;
    reg  [2:0]  state_q;
    reg  [1:0]  sel_q;
    reg         byte_q;
    reg  [11:0] addr_q;
    reg  [7:0]  wdata_q;
    wire        wr_en;
    wire        rd_setup;
    wire        mapped;
    wire        xfer_last;
    wire        xfer_done;
    wire [3:0]  last_in;
    wire        adc_on;
    wire        adc_on_rise;
    reg  [31:0] rd_mux;
// ----------------------------------------------------------------
// APB slave
// ----------------------------------------------------------------
    assign mapped   = (paddr[1:0] == 2'h0) &&
                      ((paddr == `RFD_CH0_CTL_ADDR)  || (paddr == `RFD_CH0_CFG_ADDR) ||
                       (paddr == `RFD_CH1_CTL_ADDR)  || (paddr == `RFD_CH1_CFG_ADDR) ||
                       (paddr == `RFD_ADC_BASE_ADDR) || (paddr == `RFD_ADC_CTL_ADDR) ||
                       (paddr == `RFD_STATUS_ADDR));
    assign pready   = psel & penable;
    assign pslverr  = psel & penable & ~mapped;
    assign wr_en    = psel & penable & pwrite & mapped;
    assign rd_setup = psel & ~penable & ~pwrite;
    // Read data is taken in the setup cycle so prdata comes from a flop
    always @*
    begin
        rd_mux = 32'h00000000;
        case (paddr)
            `RFD_CH0_CTL_ADDR:  rd_mux = {24'h000000, ctl_q[0]};
            `RFD_CH1_CTL_ADDR:  rd_mux = {24'h000000, ctl_q[1]};
            `RFD_CH0_CFG_ADDR:  rd_mux = {cfg_q[0][31:24], cur_q[0][7:0], cfg_q[0][15:0]};
            `RFD_CH1_CFG_ADDR:  rd_mux = {cfg_q[1][31:24], cur_q[1][7:0], cfg_q[1][15:0]};
            `RFD_ADC_BASE_ADDR: rd_mux = {25'h0000000, adc_base_q};
            `RFD_ADC_CTL_ADDR:  rd_mux = {24'h000000, adc_ctl_q};
            `RFD_STATUS_ADDR:   rd_mux = {24'h000000, adc_pend_q, state_q, adc_in_q};
            default:            rd_mux = 32'h00000000;
        endcase
    end
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= 32'h00000000;
        else if (rd_setup)
            prdata <= rd_mux;
    end
// ----------------------------------------------------------------
// General channels
// ----------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1)
        begin : gen_ch
            wire [11:0] ctl_addr;
            wire [11:0] cfg_addr;
            wire        ctl_wr;
            wire        done_here;
            wire [11:0] step;
            wire        at_end;
            assign ctl_addr = (g == 0) ? `RFD_CH0_CTL_ADDR : `RFD_CH1_CTL_ADDR;
            assign cfg_addr = (g == 0) ? `RFD_CH0_CFG_ADDR : `RFD_CH1_CFG_ADDR;
            assign ctl_wr   = wr_en && (paddr == ctl_addr) && pstrb[0];
            assign per_a[g]   = {`RFD_PERIPH_NIBBLE, cfg_q[g][`RFD_CFG_IO_LSB +: 8]};
            assign start_a[g] = {cfg_q[g][`RFD_CFG_HI_LSB +: 4],
                                 cfg_q[g][`RFD_CFG_START_LSB +: 8]};
            assign end_a[g]   = {cfg_q[g][`RFD_CFG_HI_LSB + 4 +: 4],
                                 cfg_q[g][`RFD_CFG_END_LSB +: 8]};
            // Requests only count while enabled; source picked by the low control bits
            assign ch_req[g] = ctl_q[g][`RFD_CTL_ON] &
                               dma_trig[ctl_q[g][`RFD_CTL_RSS_MSB:`RFD_CTL_RSS_LSB]];
            assign done_here = xfer_done && (sel_q == g);
            assign step      = ctl_q[g][`RFD_CTL_WORD] ? 12'h002 : 12'h001;
            // Word mode counts the end as served once its pair covers it
            assign at_end    = ((cur_q[g] + step - 12'h001) >= end_a[g]);
            always @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                begin
                    ctl_q[g]    <= `RFD_CTL_RESET;
                    cfg_q[g]    <= `RFD_CFG_RESET;
                    cur_q[g]    <= 12'h000;
                    irq_ch_q[g] <= 1'b0;
                end
                else
                begin
                    irq_ch_q[g] <= done_here && at_end && ctl_q[g][`RFD_CTL_IRQ];
                    if (wr_en && (paddr == cfg_addr))
                    begin
                        if (pstrb[0])
                            cfg_q[g][7:0]   <= pwdata[7:0];
                        if (pstrb[1])
                            cfg_q[g][15:8]  <= pwdata[15:8];
                        if (pstrb[2])
                            cfg_q[g][23:16] <= pwdata[23:16];
                        if (pstrb[3])
                            cfg_q[g][31:24] <= pwdata[31:24];
                    end
                    // Software control write wins over the hardware enable clear
                    if (ctl_wr)
                    begin
                        ctl_q[g] <= pwdata[7:0];
                        cur_q[g] <= start_a[g];
                    end
                    else if (done_here)
                    begin
                        if (!at_end)
                            cur_q[g] <= cur_q[g] + step;
                        else if (ctl_q[g][`RFD_CTL_LOOP])
                            cur_q[g] <= start_a[g];
                        else
                            ctl_q[g][`RFD_CTL_ON] <= 1'b0;
                    end
                end
            end
        end
    endgenerate

    assign irq_ch0 = irq_ch_q[0];
    assign irq_ch1 = irq_ch_q[1];
// ----------------------------------------------------------------
// Transfer engine
// ----------------------------------------------------------------
    assign bus_req   = (state_q != `RFD_S_IDLE);
    assign sys_rd    = (state_q == `RFD_S_RD);
    assign sys_wr    = (state_q == `RFD_S_WR);
    assign sys_addr  = addr_q;
    assign sys_wdata = wdata_q;
    assign xfer_last = (sel_q == `RFD_SEL_ADC) ? byte_q :
                       (~ctl_q[sel_q[0]][`RFD_CTL_WORD] | byte_q);
    assign xfer_done = (state_q == `RFD_S_WR) && xfer_last;
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_q <= `RFD_S_IDLE;
            sel_q   <= 2'h0;
            byte_q  <= 1'b0;
            addr_q  <= 12'h000;
            wdata_q <= 8'h00;
        end
        else
        begin
            case (state_q)
                `RFD_S_IDLE:
                begin
                    byte_q <= 1'b0;
                    if (adc_pend_q && adc_on)
                    begin
                        sel_q   <= `RFD_SEL_ADC;
                        state_q <= `RFD_S_REQ;
                    end
                    else if (ch_req[0])
                    begin
                        sel_q   <= 2'h0;
                        state_q <= `RFD_S_REQ;
                    end
                    else if (ch_req[1])
                    begin
                        sel_q   <= 2'h1;
                        state_q <= `RFD_S_REQ;
                    end
                end
                `RFD_S_REQ:
                begin
                    if (bus_gnt)
                    begin
                        if (sel_q == `RFD_SEL_ADC)
                        begin
                            addr_q  <= {adc_base_q, adc_in_q, 1'b0};
                            wdata_q <= adc_res_q[15:8];
                            state_q <= `RFD_S_WR;
                        end
                        else
                        begin
                            addr_q  <= xfer_addr(1'b0, ctl_q[sel_q[0]][`RFD_CTL_DIR],
                                                 cur_q[sel_q[0]], per_a[sel_q[0]], 1'b0);
                            state_q <= `RFD_S_RD;
                        end
                    end
                end
                `RFD_S_RD:
                    state_q <= `RFD_S_CAP;
                `RFD_S_CAP:
                begin
                    wdata_q <= sys_rdata;
                    addr_q  <= xfer_addr(1'b1, ctl_q[sel_q[0]][`RFD_CTL_DIR],
                                         cur_q[sel_q[0]], per_a[sel_q[0]], byte_q);
                    state_q <= `RFD_S_WR;
                end
                `RFD_S_WR:
                begin
                    if (xfer_last)
                        state_q <= `RFD_S_IDLE;
                    else if (sel_q == `RFD_SEL_ADC)
                    begin
                        byte_q  <= 1'b1;
                        addr_q  <= addr_q + 12'h001;
                        wdata_q <= adc_res_q[7:0];
                    end
                    else
                    begin
                        byte_q  <= 1'b1;
                        addr_q  <= xfer_addr(1'b0, ctl_q[sel_q[0]][`RFD_CTL_DIR],
                                             cur_q[sel_q[0]], per_a[sel_q[0]], 1'b1);
                        state_q <= `RFD_S_RD;
                    end
                end
                default:
                    state_q <= `RFD_S_IDLE;
            endcase
        end
    end
// ----------------------------------------------------------------
// Converter scan channel
// ----------------------------------------------------------------
    assign adc_on  = adc_ctl_q[`RFD_ACTL_ON];
    // Counts above the last input are clamped so the scan never runs past input eleven
    assign last_in = (adc_ctl_q[`RFD_ACTL_CNT_MSB:`RFD_ACTL_CNT_LSB] > `RFD_ADC_LAST_INPUT) ?
                     `RFD_ADC_LAST_INPUT : adc_ctl_q[`RFD_ACTL_CNT_MSB:`RFD_ACTL_CNT_LSB];
    assign adc_on_rise = wr_en && (paddr == `RFD_ADC_CTL_ADDR) && pstrb[0] &&
                         pwdata[`RFD_ACTL_ON] && !adc_on;

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            adc_base_q  <= `RFD_ADC_BASE_RESET;
            adc_ctl_q   <= `RFD_CTL_RESET;
            adc_in_q    <= 4'h0;
            adc_pend_q  <= 1'b0;
            adc_res_q   <= 16'h0000;
            adc_start_q <= 1'b0;
            irq_adc_q   <= 1'b0;
        end
        else
        begin
            adc_start_q <= 1'b0;
            irq_adc_q   <= 1'b0;
            if (wr_en && (paddr == `RFD_ADC_BASE_ADDR) && pstrb[0])
                adc_base_q <= pwdata[6:0];
            if (wr_en && (paddr == `RFD_ADC_CTL_ADDR) && pstrb[0])
                adc_ctl_q <= pwdata[7:0];
            // A new result arriving as the old one is taken keeps pending set
            if (adc_done && adc_on)
            begin
                adc_res_q  <= adc_result;
                adc_pend_q <= 1'b1;
            end
            else if (!adc_on ||
                     (state_q == `RFD_S_REQ && bus_gnt && sel_q == `RFD_SEL_ADC))
                adc_pend_q <= 1'b0;
            if (adc_on_rise)
            begin
                adc_in_q    <= 4'h0;
                adc_start_q <= 1'b1;
            end
            else if (xfer_done && sel_q == `RFD_SEL_ADC)
            begin
                adc_start_q <= 1'b1;
                if (adc_in_q >= last_in)
                begin
                    adc_in_q  <= 4'h0;
                    irq_adc_q <= adc_ctl_q[`RFD_ACTL_IRQ];
                end
                else
                    adc_in_q <= adc_in_q + 4'h1;
            end
        end
    end
    assign adc_start     = adc_start_q;
    assign adc_input_sel = adc_in_q;
    assign irq_adc       = irq_adc_q;
endmodule // rfd_dma

// ### hw/rfd_regs.vh
// Purpose : Register map, field positions and state codes of the register file DMA
// Assumes : APB byte addresses, 12-bit address space, 32-bit data words
// Notes   : Included by rfd_dma.v only

`ifndef RFD_REGS_VH
`define RFD_REGS_VH

// ----------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------
`define RFD_CH0_CTL_ADDR   12'hFB0
`define RFD_CH0_CFG_ADDR   12'hFB4
`define RFD_CH1_CTL_ADDR   12'hFB8
`define RFD_CH1_CFG_ADDR   12'hFBC
`define RFD_ADC_BASE_ADDR  12'hFC0
`define RFD_ADC_CTL_ADDR   12'hFC4
`define RFD_STATUS_ADDR    12'hFC8

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define RFD_CTL_RESET      8'h00
`define RFD_CFG_RESET      32'h00000000
`define RFD_ADC_BASE_RESET 7'h00

// ----------------------------------------------------------------
// General channel control fields
// ----------------------------------------------------------------
`define RFD_CTL_ON         7
`define RFD_CTL_LOOP       6
`define RFD_CTL_DIR        5
`define RFD_CTL_IRQ        4
`define RFD_CTL_WORD       3
`define RFD_CTL_RSS_MSB    2
`define RFD_CTL_RSS_LSB    0

// Configuration word lanes: peripheral byte, high nibbles, start, end
`define RFD_CFG_IO_LSB     0
`define RFD_CFG_HI_LSB     8
`define RFD_CFG_START_LSB  16
`define RFD_CFG_END_LSB    24

// ----------------------------------------------------------------
// Converter channel control fields
// ----------------------------------------------------------------
`define RFD_ACTL_ON        7
`define RFD_ACTL_IRQ       6
`define RFD_ACTL_CNT_MSB   3
`define RFD_ACTL_CNT_LSB   0
`define RFD_ADC_LAST_INPUT 4'hB
`define RFD_PERIPH_NIBBLE  4'hF

// ----------------------------------------------------------------
// Transfer engine states
// ----------------------------------------------------------------
`define RFD_S_IDLE         3'h0
`define RFD_S_REQ          3'h1
`define RFD_S_RD           3'h2
`define RFD_S_CAP          3'h3
`define RFD_S_WR           3'h4

`define RFD_SEL_ADC        2'h2

`endif

// ### tb/rfd_checker.sv
// Purpose : Port-level assertions for the register file DMA
// Assumes : Single pclk domain, presetn asynchronous active low
// Notes   : Bound to rfd_dma from the bench top file
`timescale 1ns/100ps
module rfd_checker
(
    input wire        pclk,
    input wire        presetn,
    input wire        psel,
    input wire        penable,
    input wire [11:0] paddr,
    input wire        pready,
    input wire        pslverr,
    input wire        bus_req,
    input wire        bus_gnt,
    input wire [11:0] sys_addr,
    input wire        sys_rd,
    input wire        sys_wr,
    input wire        adc_start,
    input wire [3:0]  adc_input_sel,
    input wire        irq_ch0,
    input wire        irq_adc
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_apb_zero_wait: assert property (pready == (psel && penable)) else $error("pready not in access cycle");
    a_ctl_mapped: assert property (psel && penable && paddr == 12'hFB0 |-> !pslverr)
        else $error("control word refused");
    a_strobe_granted: assert property ((sys_rd || sys_wr) |-> bus_req && bus_gnt)
        else $error("strobe without grant");
    a_req_release: assert property ($fell(bus_req) |-> $past(sys_wr))
        else $error("bus dropped before last write");
    a_read_then_write: assert property (sys_rd |-> ##2 sys_wr)
        else $error("read not followed by write");
    a_periph_page: assert property (sys_rd ##2 sys_wr |-> sys_addr[11:8] == 4'hF
        || $past(sys_addr[11:8], 2) == 4'hF) else $error("no peripheral page side");
    a_result_pair: assert property (sys_wr ##1 sys_wr |-> sys_addr == $past(sys_addr) + 12'h001)
        else $error("result bytes not adjacent");
    a_next_input: assert property (sys_wr ##1 sys_wr |=> adc_start && (adc_input_sel == 4'h0
        || adc_input_sel == $past(adc_input_sel) + 4'h1)) else $error("next input wrong");
    a_scan_end_irq: assert property (irq_adc |-> adc_start && adc_input_sel == 4'h0)
        else $error("scan end without wrap");
    a_irq_pulse: assert property (irq_ch0 |=> !irq_ch0) else $error("channel irq not a pulse");
    c_result_pair: cover property (sys_wr ##1 sys_wr);
    c_scan_irq: cover property (irq_adc);
    c_chan_irq: cover property (irq_ch0);
    c_refused: cover property (pslverr);
endmodule // rfd_checker

// ### tb/rfd_sys_model.sv
// Purpose : System bus partner: grant, byte memory, read data
// Assumes : Grant held until request drops
// Notes   : Read data holds one cycle, then shows inverted garbage
`timescale 1ns/100ps
module rfd_sys_model
(
    input  wire        pclk,
    input  wire        presetn,
    input  wire [2:0]  gnt_wait,
    input  wire        bus_req,
    output reg         bus_gnt,
    input  wire [11:0] sys_addr,
    input  wire        sys_rd,
    input  wire        sys_wr,
    input  wire [7:0]  sys_wdata,
    output reg  [7:0]  sys_rdata
);
    reg [7:0] mem [0:4095];
    reg [2:0] wait_q;
    integer   n_wr;
    initial n_wr = 0;
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            bus_gnt   <= 1'b0;
            wait_q    <= 3'h0;
            sys_rdata <= 8'h00;
        end
        else
        begin
            // Stall the grant to show the engine holds its request
            wait_q    <= bus_req ? wait_q + 3'h1 : 3'h0;
            bus_gnt   <= bus_req && (bus_gnt || wait_q >= gnt_wait);
            sys_rdata <= sys_rd ? mem[sys_addr] : ~sys_rdata;
            if (sys_wr)
            begin
                mem[sys_addr] <= sys_wdata;
                n_wr          <= n_wr + 1;
            end
        end
    end
endmodule // rfd_sys_model

// ### tb/rfd_tb.sv
// Purpose : Self-checking bench for the register file DMA
// Assumes : APB zero wait states, converter modelled here
// Notes   : Interrupts and write counts are polled on the falling edge; the apb task samples on the rising edge
`timescale 1ns/100ps
module tb;
    reg         pclk, presetn, psel, penable, pwrite, adc_done;
    reg  [11:0] paddr;
    reg  [31:0] pwdata;
    reg  [3:0]  pstrb;
    reg  [7:0]  dma_trig;
    reg  [15:0] adc_result;
    reg  [2:0]  gnt_wait;
    reg  [3:0]  conv_t;
    reg  [31:0] rd_q;
    reg         err_q;
    wire [31:0] prdata;
    wire [11:0] sys_addr;
    wire [7:0]  sys_wdata, sys_rdata;
    wire [3:0]  adc_input_sel;
    wire        pready, pslverr, bus_req, bus_gnt, sys_rd, sys_wr, adc_start, irq_ch0, irq_ch1, irq_adc;
    integer     n_mismatch, check_count, cyc, n_irq0, n_irq1, n_irqa, w0, i;
    rfd_dma u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready,
        .pslverr, .bus_req, .bus_gnt, .sys_addr, .sys_rd, .sys_wr, .sys_wdata, .sys_rdata, .dma_trig,
        .adc_done, .adc_result, .adc_start, .adc_input_sel, .irq_ch0, .irq_ch1, .irq_adc);
    rfd_sys_model u_sys (.pclk, .presetn, .gnt_wait, .bus_req, .bus_gnt, .sys_addr, .sys_rd, .sys_wr,
        .sys_wdata, .sys_rdata);
    initial
    begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end
    task final_report;
    begin
        if (n_mismatch == 0 && check_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    end
    endtask
    task check(input [31:0] seen, input [31:0] exp);
    begin
        check_count = check_count + 1;
        if (seen !== exp)
        begin
            n_mismatch = n_mismatch + 1;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    end
    endtask
    task apb(input w, input [11:0] a, input [31:0] d);
    begin
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        rd_q    = prdata;
        err_q   = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    end
    endtask
    // ----------------------------------------------------------------
    // Converter stand-in, timeout and interrupt counters
    // ----------------------------------------------------------------
    always @(posedge pclk)
    begin
        conv_t     <= adc_start ? 4'h4 : (conv_t != 4'h0 ? conv_t - 4'h1 : 4'h0);
        adc_done   <= (conv_t == 4'h1);
        adc_result <= {4'hC, adc_input_sel, 4'h3, adc_input_sel};
        cyc = cyc + 1;
        if (cyc == 20000)
        begin
            n_mismatch = n_mismatch + 1;
            final_report;
        end
    end
    always @(negedge pclk)
    begin
        n_irq0 = n_irq0 + (irq_ch0 === 1'b1);
        n_irqa = n_irqa + (irq_adc === 1'b1);
        n_irq1 = n_irq1 + (irq_ch1 === 1'b1);
    end
    initial
    begin
        {presetn, psel, penable, pwrite, adc_done, paddr, pwdata, dma_trig, adc_result, conv_t} = 0;
        {n_mismatch, check_count, cyc, n_irq0, n_irq1, n_irqa} = 0;
        pstrb    = 4'hF;
        gnt_wait = 3'h3;
        for (i = 0; i < 4; i = i + 1)
            u_sys.mem[12'h1FE + i] = 8'hA0 + i;
        u_sys.mem[12'hF30] = 8'h5A;
        u_sys.mem[12'hF31] = 8'hA5;
        u_sys.mem[12'h304] = 8'hEE;
        u_sys.mem[12'hA06] = 8'hEE;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, 12'hFB0, 32'h0);
        check(rd_q, 32'h0);
        apb(1'b0, 12'hFB8, 32'h0);
        check(rd_q, 32'h0);
        apb(1'b0, 12'hF00, 32'h0);
        check(err_q, 1'b1);
        // Fields written with the channel off: every trigger must be ignored
        apb(1'b1, 12'hFB0, 32'h47);
        apb(1'b0, 12'hFB0, 32'h0);
        check(rd_q, 32'h47);
        dma_trig <= 8'hFF;
        repeat (30) @(posedge pclk);
        check(u_sys.n_wr, 0);
        dma_trig <= 8'h00;
        // Single pass, bytes, RAM 1FE..201 to peripheral F20, irq on
        apb(1'b1, 12'hFB4, {8'h01, 8'hFE, 8'h21, 8'h20});
        apb(1'b1, 12'hFB0, 32'h90);
        dma_trig <= 8'h01;
        rd_q = 32'h80;
        while (rd_q[7] !== 1'b0)
            apb(1'b0, 12'hFB0, 32'h0);
        dma_trig <= 8'h00;
        check(u_sys.mem[12'hF20], 8'hA3);
        check(u_sys.n_wr, 4);
        check(n_irq0, 1);
        // Looped words from peripheral F30 into RAM 300..303
        gnt_wait <= 3'h0;
        w0 = u_sys.n_wr;
        apb(1'b1, 12'hFBC, {8'h03, 8'h00, 8'h33, 8'h30});
        apb(1'b1, 12'hFB8, 32'hE9);
        dma_trig <= 8'h02;
        while (u_sys.n_wr < w0 + 12)
            @(negedge pclk);
        @(posedge pclk);
        apb(1'b1, 12'hFB8, 32'h0);
        dma_trig <= 8'h00;
        for (i = 0; i < 4; i = i + 1)
            check(u_sys.mem[12'h300 + i], i[0] ? 8'hA5 : 8'h5A);
        check(u_sys.mem[12'h304], 8'hEE);
        check(n_irq1, 0);
        // Converter scan of inputs 0..2 into A00.., then without irq
        apb(1'b1, 12'hFC0, 32'h50);
        apb(1'b0, 12'hFC0, 32'h0);
        check(rd_q, 32'h50);
        apb(1'b1, 12'hFC4, 32'hC2);
        while (irq_adc !== 1'b1)
            @(negedge pclk);
        check(adc_input_sel, 4'h0);
        @(posedge pclk);
        apb(1'b1, 12'hFC4, 32'h81);
        repeat (80) @(posedge pclk);
        apb(1'b1, 12'hFC4, 32'h0);
        for (i = 0; i < 3; i = i + 1)
        begin
            check(u_sys.mem[12'hA00 + 2 * i], 8'hC0 + i);
            check(u_sys.mem[12'hA01 + 2 * i], 8'h30 + i);
        end
        check(u_sys.mem[12'hA06], 8'hEE);
        check(n_irqa, 1);
        final_report;
    end
endmodule // tb
bind rfd_dma rfd_checker u_chk (.pclk, .presetn, .psel, .penable, .paddr, .pready, .pslverr, .bus_req,
    .bus_gnt, .sys_addr, .sys_rd, .sys_wr, .adc_start, .adc_input_sel, .irq_ch0, .irq_adc);
